/* File: hw/clkgen_cfg.svh */
// Address map, field positions, reset values and timing of the clock gating block
`ifndef CLKGEN_CFG_SVH
`define CLKGEN_CFG_SVH

`define AV_ADDR_W      4
`define AV_DATA_W      32
`define REG_ENABLE     4'h0
`define REG_MODE       4'h4
`define REG_POWER      4'h8
`define REG_STATUS     4'hC
`define NUM_OUT        4
`define ENABLE_RST     4'hF
`define MODE_RST       1'b0
`define POWER_RST      1'b0
`define MODE_PROG_BIT  0
`define POWER_DOWN_BIT 0
`define ST_RUN_LSB     0
`define ST_STABLE_BIT  4
`define ST_SPREAD_BIT  5
`define ST_PROG_BIT    6
`define REF_PERIOD_NS  10.0
`define STABLE_TIME_MS 1.8
`define NS_PER_MS      1.0e6
`define HALF_CYC       2
`define SPREAD_PCT     0.5
`define PCT_FULL       100.0

`endif

/* File: hw/clkgen_pkg.sv */
// Shared types of the clock gating block
package clkgen_pkg;

  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} busState_e;

  typedef logic [1:0] syncPair_t;

endpackage

/* File: hw/clk_gate_lane.sv */
// One output lane: resynchronised gate and glitch-free output drive
`timescale 1ns/1ps
`include "clkgen_cfg.svh"
module clk_gate_lane
  import clkgen_pkg::*;
(
  input  wire logic ref_clk,  // Reference clock
  input  wire logic nrst,     // Synchronous reset, active low
  input  wire logic ce,       // Clock enable, freezes state when low
  input  wire logic tick,     // Last ref cycle of the low phase
  input  wire logic phaseNxt, // Next level of the master phase
  input  wire logic gateReq,  // Combined enable request
  output logic      outP,     // True output
  output logic      outN,     // Complement output
  output logic      running   // Lane is toggling
);

  syncPair_t  sync_r;
  logic       run_r;
  logic       outP_r;
  logic       outN_r;
  logic       runNxt;
  logic [2:0] waitTicks_r;

  // Run state changes only on a low-phase boundary
  assign runNxt = tick ? sync_r[1] : run_r;

  // Two-stage resync of the gate, stepped at low-phase boundaries
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sync_r <= 2'h0;
    end
    else if (ce && tick)
    begin
      sync_r <= {sync_r[0], gateReq};
    end
  end

  // Run flag follows the second stage only
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      run_r <= 1'b0;
    end
    else if (ce)
    begin
      run_r <= runNxt;
    end
  end

  // Output flops: whole periods only, held low while stopped
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      outP_r <= 1'b0;
      outN_r <= 1'b1;
    end
    else if (ce)
    begin
      outP_r <= phaseNxt & runNxt;
      outN_r <= ~(phaseNxt & runNxt);
    end
  end

  assign outP    = outP_r;
  assign outN    = outN_r;
  assign running = run_r;

  // Helper: boundaries seen while a request waits
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      waitTicks_r <= 3'h0;
    end
    else if (ce)
    begin
      if (!gateReq || run_r)
      begin
        waitTicks_r <= 3'h0;
      end
      else if (tick)
      begin
        waitTicks_r <= waitTicks_r + 3'h1;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  run_boundary_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $changed(run_r) |-> $past(tick))
    else $error("run state changed off a boundary");

  stopped_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !run_r |-> !outP_r && outN_r)
    else $error("stopped output not low");

  gate_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && tick && !sync_r[1]) |=> !run_r ##1 !outP_r)
    else $error("output kept running after gate drop");

  start_latency_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    waitTicks_r <= 3'h3)
    else $error("output start later than three boundaries");

endmodule

/* File: hw/clock_output_gating_spread_ctl.sv */
// Top of the four-output clock gating and spread control block
//
// Behaviour
// - Output runs only with pin and bit high
// - Either pin low or bit clear stops
// - Gating synchronous per output, others keep running
// - Restart emits only full-width periods
// - Start latency two to six output cycles
// - Stop at cycle boundary, held low
// - Spread pin high gives 0.5% down-spread
// - Registers take defaults at reset
// - Works from defaults and pins alone
// - Power setting writable only in program mode
// - Outputs stable within 1.8 ms
// - Serial target address fixed, outside here
`timescale 1ns/1ps
`include "clkgen_cfg.svh"
module clock_output_gating_spread_ctl
  import clkgen_pkg::*;
#(
  parameter int NOUT       = `NUM_OUT,   // Number of outputs
  parameter int HALF_CYC   = `HALF_CYC,  // Ref cycles per half period
  parameter int STABLE_CYC = $rtoi(`STABLE_TIME_MS * `NS_PER_MS / `REF_PERIOD_NS), // Stabilisation
  parameter int SPREAD_DIV = $rtoi(`PCT_FULL / `SPREAD_PCT) // Ref cycles per stretch
)
(
  input  wire logic                    ref_clk,             // Reference clock, 100 MHz
  input  wire logic                    nrst,                // Synchronous reset, active low
  input  wire logic                    ce,                  // Clock enable
  input  wire logic [NOUT-1:0]         gatePin,             // Per-output enable pins
  input  wire logic                    spread_select_pin,   // Spread request pin
  input  wire logic [`AV_ADDR_W-1:0]   address,             // Avalon byte address
  input  wire logic                    read,                // Avalon read
  input  wire logic                    write,               // Avalon write
  input  wire logic [`AV_DATA_W-1:0]   writedata,           // Avalon write data
  output logic      [`AV_DATA_W-1:0]   readdata,            // Avalon read data
  output logic                         waitrequest,         // Avalon wait
  output logic      [NOUT-1:0]         paired_clock_out_p,  // True clock outputs
  output logic      [NOUT-1:0]         paired_clock_out_n,  // Complement clock outputs
  output logic                         clkStable            // Stabilisation time passed
);

  localparam int SCW = $clog2(STABLE_CYC + 1);
  localparam int HCW = $clog2(HALF_CYC + 1);
  localparam int SPW = $clog2(SPREAD_DIV + 1);
  localparam logic [SCW-1:0] STABLE_LAST = SCW'(STABLE_CYC - 1);
  localparam logic [HCW-1:0] HALF_LAST   = HCW'(HALF_CYC - 1);
  localparam logic [SPW-1:0] SPREAD_LAST = SPW'(SPREAD_DIV - 1);

  // ****************************************
  // Register bus slave
  // ****************************************
  busState_e                busState_r;
  logic [`AV_DATA_W-1:0]    readdata_r;
  logic                     waitrequest_r;
  logic [NOUT-1:0]          enable_r;
  logic                     progMode_r;
  logic                     powerDown_r;
  logic                     wrAccept;
  logic [`AV_DATA_W-1:0]    readMux;
  logic [NOUT-1:0]          running;
  logic                     clkStable_r;
  logic                     spreadOn_r;

  // Write takes effect on the edge that ends the wait-free cycle
  assign wrAccept = ce && (busState_r == BUS_ACK) && write;

  // Request taken in idle, answered one cycle later
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      busState_r    <= BUS_IDLE;
      waitrequest_r <= 1'b1;
    end
    else if (ce)
    begin
      case (busState_r)
        BUS_IDLE:
        begin
          if (read || write)
          begin
            busState_r    <= BUS_ACK;
            waitrequest_r <= 1'b0;
          end
        end
        BUS_ACK:
        begin
          busState_r    <= BUS_IDLE;
          waitrequest_r <= 1'b1;
        end
        default:
        begin
          busState_r    <= BUS_IDLE;
          waitrequest_r <= 1'b1;
        end
      endcase
    end
  end

  // Read decode; unmapped offsets read as zero
  always_comb
  begin
    readMux = '0;
    if (address == `REG_ENABLE)
    begin
      readMux[NOUT-1:0] = enable_r;
    end
    else if (address == `REG_MODE)
    begin
      readMux[`MODE_PROG_BIT] = progMode_r;
    end
    else if (address == `REG_POWER)
    begin
      readMux[`POWER_DOWN_BIT] = powerDown_r;
    end
    else if (address == `REG_STATUS)
    begin
      readMux[`ST_RUN_LSB +: NOUT] = running;
      readMux[`ST_STABLE_BIT]      = clkStable_r;
      readMux[`ST_SPREAD_BIT]      = spreadOn_r;
      readMux[`ST_PROG_BIT]        = progMode_r;
    end
    else
    begin
      readMux = '0;
    end
  end

  // Read data captured as the request is taken
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      readdata_r <= '0;
    end
    else if (ce && busState_r == BUS_IDLE && read)
    begin
      readdata_r <= readMux;
    end
  end

  // Per-output enable bits, all set after reset
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      enable_r <= NOUT'(`ENABLE_RST);
    end
    else if (wrAccept && address == `REG_ENABLE)
    begin
      enable_r <= writedata[NOUT-1:0];
    end
  end

  // Program mode flag
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      progMode_r <= `MODE_RST;
    end
    else if (wrAccept && address == `REG_MODE)
    begin
      progMode_r <= writedata[`MODE_PROG_BIT];
    end
  end

  // Power-down setting, locked outside program mode
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      powerDown_r <= `POWER_RST;
    end
    else if (wrAccept && address == `REG_POWER && progMode_r)
    begin
      powerDown_r <= writedata[`POWER_DOWN_BIT];
    end
  end

  assign readdata    = readdata_r;
  assign waitrequest = waitrequest_r;

  // ****************************************
  // Stabilisation timer
  // ****************************************
  logic [SCW-1:0] stableCnt_r;

  // Outputs held off until the settle time has run out
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      stableCnt_r <= '0;
      clkStable_r <= 1'b0;
    end
    else if (ce && !clkStable_r)
    begin
      stableCnt_r <= stableCnt_r + SCW'(1);
      if (stableCnt_r == STABLE_LAST)
      begin
        clkStable_r <= 1'b1;
      end
    end
  end

  assign clkStable = clkStable_r;

  // ****************************************
  // Master phase and down-spread
  // ****************************************
  logic [SPW-1:0] spreadCnt_r;
  logic           stretch_r;
  logic [HCW-1:0] halfCnt_r;
  logic           phase_r;
  logic           halfDone;
  logic           tick;
  logic           phaseNxt;

  // Half period ends at its last count unless a stretch is pending
  assign halfDone = (halfCnt_r == HALF_LAST) && !stretch_r;
  assign tick     = halfDone && !phase_r;
  assign phaseNxt = halfDone ? ~phase_r : phase_r;

  // Spread pin sampled each cycle
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      spreadOn_r <= 1'b0;
    end
    else if (ce)
    begin
      spreadOn_r <= spread_select_pin;
    end
  end

  // One stretch cycle per spread interval lowers all outputs together
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      spreadCnt_r <= '0;
      stretch_r   <= 1'b0;
    end
    else if (ce)
    begin
      spreadCnt_r <= (spreadCnt_r == SPREAD_LAST) ? '0 : spreadCnt_r + SPW'(1);
      if (spreadOn_r && spreadCnt_r == SPREAD_LAST)
      begin
        stretch_r <= 1'b1;
      end
      else if (halfCnt_r == HALF_LAST)
      begin
        stretch_r <= 1'b0;
      end
    end
  end

  // Common phase; synthesis never stops for gating
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      halfCnt_r <= '0;
      phase_r   <= 1'b0;
    end
    else if (ce)
    begin
      if (halfDone)
      begin
        halfCnt_r <= '0;
        phase_r   <= ~phase_r;
      end
      else if (halfCnt_r != HALF_LAST)
      begin
        halfCnt_r <= halfCnt_r + HCW'(1);
      end
    end
  end

  // ****************************************
  // Output lanes
  // ****************************************
  logic [NOUT-1:0] gateReq;

  // Pin and bit both needed; either alone stops the output
  assign gateReq = gatePin & enable_r & {NOUT{clkStable_r && !powerDown_r}};

  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi++)
    begin : lane
      clk_gate_lane i_clk_gate_lane
      (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .ce       (ce),
        .tick     (tick),
        .phaseNxt (phaseNxt),
        .gateReq  (gateReq[gi]),
        .outP     (paired_clock_out_p[gi]),
        .outN     (paired_clock_out_n[gi]),
        .running  (running[gi])
      );
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  reset_defaults_a: assert property (@(posedge ref_clk)
    !$past(nrst) && nrst |-> enable_r == NOUT'(`ENABLE_RST) && !progMode_r && !powerDown_r)
    else $error("registers not at defaults after reset");

  pm_lock_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrAccept && address == `REG_POWER && !progMode_r) |=> $stable(powerDown_r))
    else $error("power setting changed outside program mode");

  stable_time_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(clkStable_r) |-> $past(stableCnt_r) == STABLE_LAST)
    else $error("stable flag at wrong count");

  no_early_run_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !clkStable_r |-> running == '0 && paired_clock_out_p == '0)
    else $error("output ran before stabilisation");

  spread_cause_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(stretch_r) |-> $past(spreadOn_r) && $past(spreadCnt_r) == SPREAD_LAST)
    else $error("stretch without spread request");

  bus_answer_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && busState_r == BUS_IDLE && (read || write)) |=> !waitrequest_r ##1 waitrequest_r)
    else $error("bus answer not one cycle wide");

  pair_inverse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    paired_clock_out_n == ~paired_clock_out_p)
    else $error("complement output not inverse of true output");

endmodule

/* File: verification/board_pins_model.sv */
// Board control logic that drives the gate and spread pins of the clock block
`timescale 1ns/1ps
module board_pins_model (
  input  wire logic       ref_clk,          // Reference clock
  input  wire logic [3:0] reqGate,          // Requested gate levels
  input  wire logic       reqSpread,        // Requested spread level
  output logic      [3:0] gatePin = 4'h0,   // Driven gate pins
  output logic            spreadPin = 1'b0  // Driven spread pin
);
  // Pins always carry a driven level, never left to the weak resistor
  always_ff @(posedge ref_clk)
  begin
    gatePin   <= reqGate;
    spreadPin <= reqSpread;
  end
endmodule

/* File: verification/clock_output_gating_spread_ctl_bench.sv */
// Self-checking bench of the clock gating and spread control block
`timescale 1ns/1ps
`include "clkgen_cfg.svh"
module clock_output_gating_spread_ctl_bench;
  localparam int STABLE = 40; // Shortened settle count
  localparam int SDIV   = 20; // Shortened stretch spacing
  localparam int HALF   = 2;  // Ref cycles per half period
  localparam int PER    = 2 * HALF;

  logic        ref_clk = 1'b0;
  logic        nrst;
  logic        read;
  logic        write;
  logic [3:0]  address;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  pOut;
  logic [3:0]  nOut;
  logic        ceIn;
  logic [3:0]  reqGate;
  logic [3:0]  gatePin;
  logic        reqSpread;
  logic        spreadPin;
  logic        clkStable;
  logic        spreadOk;
  int          errors = 0;
  int          checked = 0;
  int          hiLen[4] = '{0, 0, 0, 0};

  always #5 ref_clk = ~ref_clk;

  board_pins_model i_board_pins_model (
    .ref_clk   (ref_clk),
    .reqGate   (reqGate),
    .reqSpread (reqSpread),
    .gatePin   (gatePin),
    .spreadPin (spreadPin)
  );

  clock_output_gating_spread_ctl #(.STABLE_CYC(STABLE), .SPREAD_DIV(SDIV)) i_clock_output_gating_spread_ctl (
    .ref_clk            (ref_clk),
    .nrst               (nrst),
    .ce                 (ceIn),
    .gatePin            (gatePin),
    .spread_select_pin  (spreadPin),
    .address            (address),
    .read               (read),
    .write              (write),
    .writedata          (writedata),
    .readdata           (readdata),
    .waitrequest        (waitrequest),
    .paired_clock_out_p (pOut),
    .paired_clock_out_n (nOut),
    .clkStable          (clkStable)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic hang(input string msg);
    errors++;
    $display("mismatch at %0t: %s timed out", $time, msg);
    end_of_test();
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 50)
      hang("bus");
  endtask

  // Counts rising edges of one lane over a number of cycles
  task automatic edges(input int lane, input int len, output int n);
    logic prev;
    prev = pOut[lane];
    n = 0;
    repeat (len)
    begin
      @(posedge ref_clk);
      if (pOut[lane] === 1'b1 && prev === 1'b0)
        n++;
      prev = pOut[lane];
    end
  endtask

  // Every high phase is full width, or one longer while spread runs; frozen cycles do not count
  always @(posedge ref_clk)
  begin
    if (nrst === 1'b1)
      check({28'h0, nOut}, {28'h0, ~pOut}, "complement output");
    for (int i = 0; i < 4; i++)
    begin
      if (pOut[i] === 1'b1)
      begin
        if (ceIn)
          hiLen[i] <= hiLen[i] + 1;
      end
      else
      begin
        if (hiLen[i] != 0)
          check({31'h0, hiLen[i] == HALF || (spreadOk && hiLen[i] == HALF + 1)}, 32'h1, "high width");
        hiLen[i] <= 0;
      end
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int n;
    logic [31:0] q;
    nrst      = 1'b0;
    read      = 1'b0;
    write     = 1'b0;
    address   = 4'h0;
    writedata = 32'h0;
    reqGate   = 4'h0;
    reqSpread = 1'b0;
    spreadOk  = 1'b0;
    ceIn      = 1'b1;
    repeat (10) @(posedge ref_clk);
    nrst    <= 1'b1;
    reqGate <= 4'hF;
    // Defaults without any host write
    bus(1'b0, `REG_STATUS, 32'h0, q);
    check(q, 32'h0, "status at reset");
    bus(1'b0, `REG_ENABLE, 32'h0, q);
    check(q, 32'h0000000F, "enable reset");
    bus(1'b0, `REG_MODE, 32'h0, q);
    check(q, 32'h0, "mode reset");
    bus(1'b0, `REG_POWER, 32'h0, q);
    check(q, 32'h0, "power reset");
    bus(1'b0, 4'h2, 32'h0, q);
    check(q, 32'h0, "unmapped read");
    n = 0;
    while (clkStable !== 1'b1 && n < STABLE + 20)
    begin
      check({28'h0, pOut}, 32'h0, "output before settle");
      @(posedge ref_clk);
      n++;
    end
    if (n >= STABLE + 20)
      hang("settle");
    repeat (20) @(posedge ref_clk);
    for (int i = 0; i < 4; i++)
    begin
      edges(i, 10 * PER, n);
      check(n, 10, "default run");
    end
    bus(1'b0, `REG_STATUS, 32'h0, q);
    check(q, 32'h0000001F, "status when settled");
    $display("test defaults done");
    // Pin drop stops one lane low, its neighbour keeps running
    reqGate <= 4'hE;
    repeat (30) @(posedge ref_clk);
    edges(0, 10 * PER, n);
    check(n, 0, "stopped lane");
    check({31'h0, pOut[0]}, 32'h0, "stopped level");
    edges(1, 10 * PER, n);
    check(n, 10, "neighbour lane");
    // Restart latency
    @(posedge ref_clk);
    reqGate <= 4'hF;
    n = 0;
    while (pOut[0] !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100)
      hang("restart");
    check({31'h0, n >= 2 * PER && n <= 6 * PER + 1}, 32'h1, "start latency");
    $display("test gate pin done");
    // Register bit alone stops a lane
    bus(1'b1, `REG_ENABLE, 32'h0000000D, q);
    repeat (30) @(posedge ref_clk);
    edges(1, 10 * PER, n);
    check(n, 0, "bit cleared");
    edges(2, 10 * PER, n);
    check(n, 10, "bit set");
    bus(1'b1, `REG_ENABLE, 32'h0000000F, q);
    $display("test enable bit done");
    // Spread on stretches periods, then off again
    spreadOk  <= 1'b1;
    reqSpread <= 1'b1;
    repeat (10) @(posedge ref_clk);
    bus(1'b0, `REG_STATUS, 32'h0, q);
    check({31'h0, q[`ST_SPREAD_BIT]}, 32'h1, "spread sampled");
    for (int i = 0; i < 4; i++)
    begin
      edges(i, 50 * PER, n);
      check({31'h0, n >= 45 && n < 50}, 32'h1, "spread rate");
    end
    reqSpread <= 1'b0;
    repeat (20) @(posedge ref_clk);
    spreadOk <= 1'b0;
    edges(3, 50 * PER, n);
    check(n, 50, "nominal rate");
    $display("test spread done");
    // Clock enable low freezes every output where it stands
    @(posedge ref_clk);
    ceIn <= 1'b0;
    @(posedge ref_clk);
    q = {28'h0, pOut};
    repeat (8)
    begin
      @(posedge ref_clk);
      check({28'h0, pOut}, q, "frozen by enable");
    end
    ceIn <= 1'b1;
    edges(2, 10 * PER, n);
    check(n, 10, "run after freeze");
    $display("test freeze done");
    // Power setting only in program mode
    bus(1'b1, `REG_POWER, 32'h00000001, q);
    bus(1'b0, `REG_POWER, 32'h0, q);
    check(q, 32'h0, "power write in normal mode");
    edges(0, 10 * PER, n);
    check(n, 10, "still running");
    bus(1'b1, `REG_MODE, 32'h00000001, q);
    bus(1'b1, `REG_POWER, 32'h00000001, q);
    bus(1'b0, `REG_POWER, 32'h0, q);
    check(q, 32'h00000001, "power write in program mode");
    repeat (30) @(posedge ref_clk);
    for (int i = 0; i < 4; i++)
    begin
      edges(i, 10 * PER, n);
      check(n, 0, "powered down");
    end
    bus(1'b1, `REG_POWER, 32'h0, q);
    bus(1'b1, `REG_MODE, 32'h0, q);
    repeat (30) @(posedge ref_clk);
    edges(0, 10 * PER, n);
    check(n, 10, "power restored");
    $display("test power done");
    // Program mode shows in status; a second reset restores defaults
    bus(1'b1, `REG_ENABLE, 32'h0, q);
    repeat (30) @(posedge ref_clk);
    bus(1'b1, `REG_MODE, 32'h00000001, q);
    bus(1'b0, `REG_STATUS, 32'h0, q);
    check(q, 32'h00000050, "status in program mode");
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    bus(1'b0, `REG_ENABLE, 32'h0, q);
    check(q, 32'h0000000F, "enable after second reset");
    bus(1'b0, `REG_MODE, 32'h0, q);
    check(q, 32'h0, "mode after second reset");
    $display("test second reset done");
    end_of_test();
  end
endmodule
